// *** hdl/xch_defines.svh ***
// named constants of the three-port bus exchanger
// assumes inclusion by bare name from the package and the design files
`ifndef XCH_DEFINES_SVH
`define XCH_DEFINES_SVH

// ----------------------------------------------------------------
// data path
// ----------------------------------------------------------------
`define XCH_W            18
`define XCH_NPORT        3
`define XCH_LOG_W        20
`define XCH_FIFO_DEPTH   16

// ----------------------------------------------------------------
// register map (byte offsets, low address bits decoded)
// ----------------------------------------------------------------
`define XCH_ADDR_W       8
`define XCH_OFS_CTRL     8'h00
`define XCH_OFS_STATUS   8'h04
`define XCH_OFS_HELD_A   8'h08
`define XCH_OFS_HELD_B   8'h0c
`define XCH_OFS_HELD_C   8'h10
`define XCH_OFS_LOG      8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define XCH_CTRL_LOG_EN  0
`define XCH_CTRL_SEL_LO  1
`define XCH_CTRL_SEL_HI  2
`define XCH_ST_NEMPTY    0
`define XCH_ST_FULL      1
`define XCH_ST_OVF       2
`define XCH_ST_LE_LO     3
`define XCH_ST_LE_HI     5
`define XCH_HTRANS_ACT   1
`define XCH_RESP_OKAY    1'b0
`define XCH_CTRL_RST     3'h0

`endif

// *** hdl/xch_pkg.sv ***
// types shared by the bus exchanger files
// assumes the defines header is on the include path
`include "xch_defines.svh"

package xch_pkg;
    typedef logic [`XCH_W-1:0]      xch_word_type;
    typedef logic [`XCH_LOG_W-1:0]  xch_log_type;
    typedef enum logic [1:0] {
        XCH_PORT_A,
        XCH_PORT_B,
        XCH_PORT_C
    } xch_port_type;
endpackage

// *** hdl/xch_fifo.sv ***
// synchronous fifo, flip-flop storage, valid/ready on both sides
// assumes one clock, active-low asynchronous reset, power-of-two depth
`timescale 1ns/1ps
`default_nettype none
`include "xch_defines.svh"

module xch_fifo import xch_pkg::*; #(
    parameter int WIDTH = `XCH_LOG_W,
    parameter int DEPTH = `XCH_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    // handshakes; ready is a flop so it may leave the block directly
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers, fill level and ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r  <= count_nxt;
            in_ready <= (count_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule // xch_fifo
`default_nettype wire

// *** hdl/xch_exchanger.sv ***
// three-port 18-bit bus exchanger with ahb-lite status/log registers
// assumes all pins synchronous to hclk; port clocks sampled as levels
// Operation
// R1: three 18-bit two-way ports, each with a register capturing its pins
// R2: latch enable high makes the register follow its pins, clock ignored
// R3: latch enable low and clock steady: register holds previous value
// R4: latch enable low: capture pins on each rising edge of port clock
// R5: ports B and C behave like A, each with its own controls
// R6: active-low output enable; high floats port regardless of select
// R7: select picks source: A C/B, B A/C, C B/A for high/low
// R8: one port's data may leave on one or both others, live or stored
// R9: surrounding logic holds unused control inputs at defined levels
// R10: storage has no reset; contents undefined until first load
`timescale 1ns/1ps
`default_nettype none
`include "xch_defines.svh"

module xch_exchanger import xch_pkg::*; (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output var  logic [31:0]   hrdata,
    output var  logic          hreadyout,
    output var  logic          hresp,
    input  wire xch_word_type  port_a_data_in,
    output var  xch_word_type  port_a_data_out,
    output var  logic          port_a_data_oe_n,
    input  wire logic          port_a_output_enable_n,
    input  wire logic          port_a_source_select,
    input  wire logic          port_a_latch_enable,
    input  wire logic          port_a_capture_clock,
    input  wire xch_word_type  port_b_data_in,
    output var  xch_word_type  port_b_data_out,
    output var  logic          port_b_data_oe_n,
    input  wire logic          port_b_output_enable_n,
    input  wire logic          port_b_source_select,
    input  wire logic          port_b_latch_enable,
    input  wire logic          port_b_capture_clock,
    input  wire xch_word_type  port_c_data_in,
    output var  xch_word_type  port_c_data_out,
    output var  logic          port_c_data_oe_n,
    input  wire logic          port_c_output_enable_n,
    input  wire logic          port_c_source_select,
    input  wire logic          port_c_latch_enable,
    input  wire logic          port_c_capture_clock,
    output var  logic          capture_log_ready
);
    // ----------------------------------------------------------------
    // internal signals
    // ----------------------------------------------------------------
    xch_word_type              pin_in   [`XCH_NPORT];
    logic [`XCH_NPORT-1:0]     le;
    logic [`XCH_NPORT-1:0]     cap_clk;
    logic [`XCH_NPORT-1:0]     sel;
    logic [`XCH_NPORT-1:0]     oe_n;
    logic [`XCH_NPORT-1:0]     clk_prev_r;
    logic [`XCH_NPORT-1:0]     rise;
    xch_word_type              held_r   [`XCH_NPORT];
    xch_word_type              held_nxt [`XCH_NPORT];
    xch_word_type              out_r    [`XCH_NPORT];
    logic [`XCH_NPORT-1:0]     oe_n_r;
    logic [2:0]                ctrl_r;
    logic                      ovf_r;
    logic                      wr_pend_r;
    logic [`XCH_ADDR_W-1:0]    addr_r;
    logic                      take;
    logic [1:0]                log_port;
    logic                      log_valid;
    xch_log_type               log_data;
    logic                      log_out_valid;
    xch_log_type               log_out_data;
    logic                      log_pop;

    // source port feeding each output port
    function automatic xch_port_type src_of(input int i, input logic s);
        xch_port_type r;
        r = XCH_PORT_A;
        unique case (i)
            0: r = s ? XCH_PORT_C : XCH_PORT_B;
            1: r = s ? XCH_PORT_A : XCH_PORT_C;
            default: r = s ? XCH_PORT_B : XCH_PORT_A;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // pin gathering
    // ----------------------------------------------------------------
    // group the per-port pins into arrays
    assign pin_in[0] = port_a_data_in;
    assign pin_in[1] = port_b_data_in;
    assign pin_in[2] = port_c_data_in;
    assign le      = {port_c_latch_enable, port_b_latch_enable,
                      port_a_latch_enable};
    assign cap_clk = {port_c_capture_clock, port_b_capture_clock,
                      port_a_capture_clock};
    assign sel     = {port_c_source_select, port_b_source_select,
                      port_a_source_select};
    assign oe_n    = {port_c_output_enable_n, port_b_output_enable_n,
                      port_a_output_enable_n};

    // ----------------------------------------------------------------
    // universal storage elements
    // ----------------------------------------------------------------
    // previous level of each port clock, for edge detection; it tracks the
    // pin through reset too, so a clock resting high is never a false edge
    always_ff @(posedge hclk) begin
        clk_prev_r <= cap_clk; // R3
    end

    assign rise = cap_clk & ~clk_prev_r;

    // live value when transparent or capturing, else the held value
    always_comb begin
        for (int i = 0; i < `XCH_NPORT; i++) begin
            if (le[i]) begin
                held_nxt[i] = pin_in[i]; // R2 R8
            end else if (rise[i]) begin
                held_nxt[i] = pin_in[i]; // R4
            end else begin
                held_nxt[i] = held_r[i]; // R3
            end
        end
    end

    // storage registers carry no reset, one per port
    always_ff @(posedge hclk) begin
        for (int i = 0; i < `XCH_NPORT; i++) begin
            held_r[i] <= held_nxt[i]; // R1 R5 R10
        end
    end

    // ----------------------------------------------------------------
    // output selection and drive
    // ----------------------------------------------------------------
    // each port shows the next value of its chosen source register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `XCH_NPORT; i++) begin
                out_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `XCH_NPORT; i++) begin
                out_r[i] <= held_nxt[src_of(i, sel[i])]; // R7 R8
            end
        end
    end

    // enables float all ports while reset holds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_n_r <= '1;
        end else begin
            oe_n_r <= oe_n; // R6
        end
    end

    assign port_a_data_out  = out_r[0];
    assign port_b_data_out  = out_r[1];
    assign port_c_data_out  = out_r[2];
    assign port_a_data_oe_n = oe_n_r[0];
    assign port_b_data_oe_n = oe_n_r[1];
    assign port_c_data_oe_n = oe_n_r[2];

    // ----------------------------------------------------------------
    // capture log
    // ----------------------------------------------------------------
    // clocked captures of the chosen port are logged with the port id
    assign log_port  = ctrl_r[`XCH_CTRL_SEL_HI:`XCH_CTRL_SEL_LO];
    assign log_valid = ctrl_r[`XCH_CTRL_LOG_EN]
                       && (log_port < 2'(`XCH_NPORT))
                       && rise[log_port] && !le[log_port];
    assign log_data  = {log_port, pin_in[log_port]};

    xch_fifo #(
        .WIDTH (`XCH_LOG_W),
        .DEPTH (`XCH_FIFO_DEPTH)
    ) u_log_fifo (
        .clk       (hclk),
        .rst_n     (hresetn),
        .in_valid  (log_valid),
        .in_ready  (capture_log_ready),
        .in_data   (log_data),
        .out_valid (log_out_valid),
        .out_ready (log_pop),
        .out_data  (log_out_data)
    );

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    assign take = hsel && htrans[`XCH_HTRANS_ACT] && hready;
    assign log_pop = take && !hwrite
                     && (haddr[`XCH_ADDR_W-1:0] == `XCH_OFS_LOG);

    // read mux; control forwarded from a write in its data phase
    function automatic logic [31:0] rd_mux(
        input logic [`XCH_ADDR_W-1:0] a);
        logic [31:0] d;
        logic [2:0]  c;
        d = '0;
        c = (wr_pend_r && addr_r == `XCH_OFS_CTRL) ? hwdata[2:0] : ctrl_r;
        unique case (a)
            `XCH_OFS_CTRL:   d[2:0] = c;
            `XCH_OFS_STATUS: begin
                d[`XCH_ST_NEMPTY] = log_out_valid;
                d[`XCH_ST_FULL]   = !capture_log_ready;
                d[`XCH_ST_OVF]    = ovf_r;
                d[`XCH_ST_LE_HI:`XCH_ST_LE_LO] = le;
            end
            `XCH_OFS_HELD_A: d[`XCH_W-1:0] = held_r[0];
            `XCH_OFS_HELD_B: d[`XCH_W-1:0] = held_r[1];
            `XCH_OFS_HELD_C: d[`XCH_W-1:0] = held_r[2];
            `XCH_OFS_LOG:    d[`XCH_LOG_W-1:0] =
                                 log_out_valid ? log_out_data : '0;
            default:         d = '0;
        endcase
        return d;
    endfunction

    // address phase capture; zero-wait, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= `XCH_RESP_OKAY;
        end else begin
            wr_pend_r <= take && hwrite;
            if (take) begin
                addr_r <= haddr[`XCH_ADDR_W-1:0];
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux(haddr[`XCH_ADDR_W-1:0]);
            end
        end
    end

    // control register written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `XCH_CTRL_RST;
        end else if (wr_pend_r && addr_r == `XCH_OFS_CTRL) begin
            ctrl_r <= hwdata[2:0];
        end
    end

    // overflow sticky: a lost capture beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_r <= 1'b0;
        end else if (log_valid && !capture_log_ready) begin
            ovf_r <= 1'b1;
        end else if (wr_pend_r && addr_r == `XCH_OFS_STATUS
                     && hwdata[`XCH_ST_OVF]) begin
            ovf_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_transparent;
        @(posedge hclk) disable iff (!hresetn)
        port_a_latch_enable |=> held_r[0] == $past(port_a_data_in);
    endproperty
    a_transparent: assert property (p_transparent) // R2
        else $error("transparent register did not follow pins");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!port_b_latch_enable && (port_b_capture_clock == clk_prev_r[1]))
        |=> $stable(held_r[1]);
    endproperty
    a_hold: assert property (p_hold) // R3
        else $error("latched register changed without an edge");

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        (!port_c_latch_enable && port_c_capture_clock && !clk_prev_r[2])
        |=> held_r[2] == $past(port_c_data_in);
    endproperty
    a_capture: assert property (p_capture) // R4
        else $error("rising port clock did not capture pins");

    property p_own_controls;
        @(posedge hclk) disable iff (!hresetn)
        (!port_b_latch_enable && !rise[1]) ##1
        (!port_b_latch_enable && !rise[1]) |=> $stable(held_r[1]);
    endproperty
    a_own_controls: assert property (p_own_controls) // R5
        else $error("port b register moved under other controls");

    property p_float;
        @(posedge hclk) disable iff (!hresetn)
        port_c_output_enable_n |=> port_c_data_oe_n;
    endproperty
    a_float: assert property (p_float) // R6
        else $error("port drove while its enable was high");

    property p_sel_a;
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && port_a_source_select && port_c_latch_enable)
        |=> port_a_data_out == $past(port_c_data_in);
    endproperty
    a_sel_a: assert property (p_sel_a) // R7
        else $error("port a did not show live port c data");

    property p_sel_b;
        @(posedge hclk) disable iff (!hresetn)
        (hresetn && !port_b_source_select)
        |=> port_b_data_out == held_r[2];
    endproperty
    a_sel_b: assert property (p_sel_b) // R7
        else $error("port b did not show port c register");

    property p_fanout;
        @(posedge hclk) disable iff (!hresetn)
        (!port_a_source_select && port_c_source_select)
        |=> port_a_data_out == port_c_data_out;
    endproperty
    a_fanout: assert property (p_fanout) // R8
        else $error("two outputs of one source disagree");

    property p_okay;
        @(posedge hclk) disable iff (!hresetn)
        take |=> hreadyout && hresp == `XCH_RESP_OKAY;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready or not okay");
endmodule // xch_exchanger
`default_nettype wire

// *** verif/xch_bus_model.sv ***
// external parallel bus on one port of the exchanger
// assumes one instance per port, clocked by the bench clock
`timescale 1ns/1ps
`default_nettype none

module xch_bus_model import xch_pkg::*; (
    input  wire logic         clk,
    input  wire xch_word_type dev_data,
    input  wire logic         dev_oe_n,
    input  wire logic         ext_en,
    input  wire xch_word_type ext_data,
    output var  xch_word_type bus_level
);
    xch_word_type last_r = '0;

    // remember the last level that somebody drove
    always @(posedge clk) begin
        if (!dev_oe_n || ext_en) begin
            last_r <= bus_level;
        end
    end

    // released wire shows the inverse of its last level, never a stale copy
    always_comb begin
        if (!dev_oe_n) begin
            bus_level = dev_data;
        end else if (ext_en) begin
            bus_level = ext_data;
        end else begin
            bus_level = ~last_r;
        end
    end
endmodule // xch_bus_model
`default_nettype wire

// *** verif/three_port_bus_exchanger_test.sv ***
// self-checking bench of the three-port bus exchanger
// assumes the exchanger, its package and a bus model on every port
`timescale 1ns/1ps
`default_nettype none
`include "xch_defines.svh"

module three_port_bus_exchanger_test import xch_pkg::*; ;
    logic         hclk = 1'b0;
    logic         hresetn, hsel, hwrite;
    logic [1:0]   htrans;
    logic [31:0]  haddr, hwdata;
    wire  [31:0]  hrdata;
    wire          hreadyout, hresp, log_rdy;
    wire  xch_word_type dout [3];
    wire  xch_word_type bus [3];
    wire          doen [3];
    xch_word_type drv [3];
    logic         oen [3], sel [3], le [3], ck [3], den [3];
    int           num_errors, compares, cycles;

    always #2.5 hclk = ~hclk;

    xch_exchanger u_xch_exchanger (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .capture_log_ready(log_rdy),
        .port_a_data_in(bus[0]), .port_a_data_out(dout[0]),
        .port_a_data_oe_n(doen[0]), .port_a_output_enable_n(oen[0]),
        .port_a_source_select(sel[0]), .port_a_latch_enable(le[0]),
        .port_a_capture_clock(ck[0]),
        .port_b_data_in(bus[1]), .port_b_data_out(dout[1]),
        .port_b_data_oe_n(doen[1]), .port_b_output_enable_n(oen[1]),
        .port_b_source_select(sel[1]), .port_b_latch_enable(le[1]),
        .port_b_capture_clock(ck[1]),
        .port_c_data_in(bus[2]), .port_c_data_out(dout[2]),
        .port_c_data_oe_n(doen[2]), .port_c_output_enable_n(oen[2]),
        .port_c_source_select(sel[2]), .port_c_latch_enable(le[2]),
        .port_c_capture_clock(ck[2])
    );

    // one bus model per port resolves the two-way wire
    for (genvar i = 0; i < 3; i++) begin : g_bus
        xch_bus_model u_xch_bus_model (
            .clk(hclk), .dev_data(dout[i]), .dev_oe_n(doen[i]),
            .ext_en(den[i]), .ext_data(drv[i]), .bus_level(bus[i])
        );
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task finish_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // source port feeding output q for select s: a maps to index 0
    function automatic int src(int q, logic s);
        return s ? (q + 2) % 3 : (q + 1) % 3;
    endfunction

    task wait_rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // one single ahb-lite transfer, read data taken at the data-phase edge
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
        chk_bit(hresp, 1'b0);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk_val(r, exp);
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    // port p transparent, held, isolated, then clocked, seen on both others
    task t_port(input int p, input xch_word_type v);
        @(posedge hclk);
        for (int q = 0; q < 3; q++) begin
            oen[q] <= (q == p);
            den[q] <= (q == p);
            sel[q] <= (src(q, 1'b1) == p);
            le[q] <= 1'b0;
        end
        @(posedge hclk);
        le[p] <= 1'b1;
        drv[p] <= v;
        ck[p] <= ~ck[p];
        @(posedge hclk);
        #1;
        for (int q = 0; q < 3; q++) if (q != p) chk_val(dout[q], v);
        for (int q = 0; q < 3; q++) if (q != p) chk_bit(doen[q], 1'b0);
        @(posedge hclk);
        le[p] <= 1'b0;
        ck[p] <= 1'b1;
        drv[p] <= ~v;
        @(posedge hclk);
        @(posedge hclk);
        #1;
        for (int q = 0; q < 3; q++) if (q != p) chk_val(dout[q], v);
        @(posedge hclk);
        for (int q = 0; q < 3; q++) if (q != p) le[q] <= 1'b1;
        for (int q = 0; q < 3; q++) if (q != p) ck[q] <= 1'b1;
        @(posedge hclk);
        #1;
        for (int q = 0; q < 3; q++) if (q != p) chk_val(dout[q], v);
        @(posedge hclk);
        ck[p] <= 1'b0;
        for (int q = 0; q < 3; q++) if (q != p) le[q] <= 1'b0;
        for (int q = 0; q < 3; q++) if (q != p) ck[q] <= 1'b0;
        @(posedge hclk);
        ck[p] <= 1'b1;
        @(posedge hclk);
        #1;
        for (int q = 0; q < 3; q++)
            if (q != p) chk_val(dout[q], xch_word_type'(~v));
        $display("test port %0d done", p);
    endtask

    // load all three, then every select value, then float every port
    task t_select;
        xch_word_type val [3] = '{18'h12345, 18'h2abcd, 18'h05a5a};
        @(posedge hclk);
        for (int i = 0; i < 3; i++) begin
            oen[i] <= 1'b1;
            den[i] <= 1'b1;
            drv[i] <= val[i];
        end
        @(posedge hclk);
        for (int i = 0; i < 3; i++) le[i] <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 3; i++) begin
            le[i] <= 1'b0;
            den[i] <= 1'b0;
            oen[i] <= 1'b0;
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge hclk);
            for (int i = 0; i < 3; i++) sel[i] <= s[0];
            @(posedge hclk);
            #1;
            for (int i = 0; i < 3; i++) chk_val(dout[i], val[src(i, s[0])]);
        end
        for (int i = 0; i < 3; i++) rd_chk(`XCH_OFS_HELD_A + 8'(4 * i), val[i]);
        @(posedge hclk);
        for (int i = 0; i < 3; i++) oen[i] <= 1'b1;
        for (int i = 0; i < 3; i++) sel[i] <= 1'b1;
        @(posedge hclk);
        #1;
        for (int i = 0; i < 3; i++) chk_bit(doen[i], 1'b1);
        $display("test select done");
    endtask

    // a second reset leaves the storage alone
    task t_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk_bit(doen[0], 1'b1);
        @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(`XCH_OFS_HELD_B, 32'h0002abcd);
        $display("test reset done");
    endtask

    // control readback, unmapped place, latch enables in status
    task t_regs;
        wr(`XCH_OFS_CTRL, 32'h5);
        rd_chk(`XCH_OFS_CTRL, 32'h5);
        wr(`XCH_OFS_CTRL, 32'h7);
        rd_chk(`XCH_OFS_CTRL, 32'h7);
        wr(`XCH_OFS_CTRL, 32'h0);
        rd_chk(`XCH_OFS_CTRL, 32'h0);
        wr(8'h18, 32'hffffffff);
        rd_chk(8'h18, 32'h0);
        @(posedge hclk);
        le[0] <= 1'b1;
        le[2] <= 1'b1;
        rd_chk(`XCH_OFS_STATUS, 32'h28);
        @(posedge hclk);
        le[0] <= 1'b0;
        le[2] <= 1'b0;
        $display("test regs done");
    endtask

    // log port a captures until the fifo refuses, then drain it
    task t_log;
        den[0] <= 1'b1;
        wr(`XCH_OFS_CTRL, 32'h1);
        for (int k = 0; k < 17; k++) begin
            @(posedge hclk);
            ck[0] <= 1'b0;
            drv[0] <= 18'h00100 + 18'(k);
            @(posedge hclk);
            ck[0] <= 1'b1;
        end
        repeat (3) @(posedge hclk);
        #1;
        chk_bit(log_rdy, 1'b0);
        rd_chk(`XCH_OFS_STATUS, 32'h7);
        for (int k = 0; k < 16; k++) rd_chk(`XCH_OFS_LOG, 32'h100 + k);
        rd_chk(`XCH_OFS_LOG, 32'h0);
        rd_chk(`XCH_OFS_STATUS, 32'h4);
        wr(`XCH_OFS_STATUS, 32'h4);
        rd_chk(`XCH_OFS_STATUS, 32'h0);
        chk_bit(log_rdy, 1'b1);
        $display("test log done");
    endtask

    // cut a hang short
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("BAD at %0t: timeout", $time);
            finish_test;
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        // storage is loaded with zero while reset holds, so outputs are known
        for (int i = 0; i < 3; i++) begin
            oen[i] = 1'b1;
            sel[i] = 1'b0;
            le[i] = 1'b1;
            ck[i] = 1'b0;
            den[i] = 1'b1;
            drv[i] = '0;
        end
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 3; i++) le[i] <= 1'b0;
        for (int i = 0; i < 3; i++) den[i] <= 1'b0;
        for (int p = 0; p < 3; p++) t_port(p, 18'h2c3a5 ^ 18'(p));
        t_select;
        t_reset;
        t_regs;
        t_log;
        finish_test;
    end
endmodule // three_port_bus_exchanger_test
`default_nettype wire
